// File: pkg/ref_i2c_pkg.sv
// Constants and types for the reference-control two-wire slave
`default_nettype none
package ref_i2c_pkg;

   // ****************************************
   // Address and command fields
   // ****************************************
   localparam logic [3:0] ADDR_FIXED = 4'h9;
   localparam logic [3:0] CMD_REF_STATIC = 4'h8;
   localparam logic [3:0] CMD_REF_FLEX = 4'h9;
   localparam int COMMAND_FIELD_TOP_BIT = 23;
   localparam int FLEXIBLE_MODE_BIT = 14;
   localparam int REF_OPTION_HIGH_BIT = 13;
   localparam int REF_OPTION_LOW_BIT = 12;
   localparam int REF_POWER_BIT = 4;
   localparam logic [1:0] OPT_TRACK = 2'h0;
   localparam logic [1:0] OPT_ALWAYS_ON = 2'h1;
   localparam logic [1:0] OPT_ALWAYS_OFF = 2'h2;

   // ****************************************
   // Three-level address pin codes
   // ****************************************
   localparam logic [1:0] PIN_LOW = 2'h0;
   localparam logic [1:0] PIN_HIGH = 2'h1;
   localparam logic [1:0] PIN_FLOAT = 2'h2;

   // ****************************************
   // Bit counter and synchroniser layout
   // ****************************************
   localparam logic [3:0] BIT_NONE = 4'h0;
   localparam logic [3:0] BIT_FIRST = 4'h1;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam int SYNC_W = 7;
   localparam int SYNC_SCL = 0;
   localparam int SYNC_SDA = 1;
   localparam int SYNC_LOW0 = 2;
   localparam int SYNC_HIGH0 = 4;
   localparam int SYNC_CMD = 6;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h03;

   // ****************************************
   // States and reset values
   // ****************************************
   typedef enum logic [5:0] {
      PH_ADDR = 6'h01,
      PH_CMD = 6'h02,
      PH_MSB = 6'h04,
      PH_LSB = 6'h08,
      PH_READ = 6'h10,
      PH_IGNORE = 6'h20
   } phase_t;

   typedef enum logic [3:0] {
      REF_STATIC = 4'h1,
      REF_FLEX_TRACK = 4'h2,
      REF_FLEX_ON = 4'h4,
      REF_FLEX_OFF = 4'h8
   } ref_mode_t;

   localparam ref_mode_t REF_MODE_RESET = REF_STATIC;
   localparam logic STATIC_EN_RESET = 1'b0;
   localparam logic REF_POWER_RESET = 1'b0;
   localparam logic [7:0] STATUS_RESET = 8'h00;

endpackage
`default_nettype wire

// File: design/ref_control_i2c_slave.sv
// Two-wire slave front end with on-chip reference power control
// Behaviour
// - Reference command: address plus three command bytes
// - External reference in use forces unity gain
// - Release shared reference pin when reference off
// - Power-on: reference off, static default state
// - Static code 1000: power bit sets reference
// - Static and method one track channel power
// - Flexible 100 selects tracking of channel power
// - Flexible 101 keeps reference always on
// - Flexible 110 with power bit zero: always off
// - Flexible ignores static; bit clear returns static
// - Slave only: receive writes, send on reads
// - Works at standard, fast, fast-plus, high-speed
// - Seven-bit addresses only, no general call
// - Ninth clock carries acknowledge, low means ack
// - Start is data falling while clock high
// - Acknowledge address only on match, else silent
// - Address is 1001 then three pin bits
// - Command in upper nibble, selector lower
// - Execute on falling edge after low byte ack
// - Stop releases bus, await new start
`timescale 1ns/1ns
`default_nettype none
module ref_control_i2c_slave
   import ref_i2c_pkg::*;
(
   // System clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Two-wire link, the clock doubles as the link domain clock
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Three-level address straps
   input wire logic [1:0] slave_select_pin_high_i,
   input wire logic [1:0] slave_select_pin_low_i,
   // Channel power state from the converter core
   input wire logic [7:0] channel_active_i,
   // Reference control outputs
   output logic ref_power_o,
   output logic gain_one_o,
   output logic ref_pin_drive_o,
   output logic flexible_mode_o
);

   // ****************************************
   // Pin synchronisers (system domain)
   // ****************************************
   logic [SYNC_W-1:0] sync_raw, sync_s1, sync_s2, sync_s3, pin_q;
   logic cmd_tog = 1'b0;

   assign sync_raw = {cmd_tog, slave_select_pin_high_i, slave_select_pin_low_i, sda_i, scl_i};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++)
      begin : g_sync
         // A change is taken only once the second and third stages agree
         always_ff @(posedge clk_i)
         begin
            if (srst_i)
            begin
               sync_s1[gi] <= SYNC_RESET[gi];
               sync_s2[gi] <= SYNC_RESET[gi];
               sync_s3[gi] <= SYNC_RESET[gi];
               pin_q[gi] <= SYNC_RESET[gi];
            end
            else
            begin
               sync_s1[gi] <= sync_raw[gi];
               sync_s2[gi] <= sync_s1[gi];
               sync_s3[gi] <= sync_s2[gi];
               if (sync_s2[gi] == sync_s3[gi])
                  pin_q[gi] <= sync_s3[gi];
            end
         end
      end
   endgenerate

   // ****************************************
   // Start and stop detection
   // ****************************************
   logic scl_prev, sda_prev, frame_open, cmd_prev;
   logic frame_gen = 1'b0; // Kept through reset so the next start always reads as new
   wire start_det = scl_prev && pin_q[SYNC_SCL] && sda_prev && !pin_q[SYNC_SDA];
   wire stop_det = scl_prev && pin_q[SYNC_SCL] && !sda_prev && pin_q[SYNC_SDA];
   wire cmd_evt = pin_q[SYNC_CMD] != cmd_prev;

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         frame_open <= 1'b0;
         cmd_prev <= 1'b0;
      end
      else
      begin
         scl_prev <= pin_q[SYNC_SCL];
         sda_prev <= pin_q[SYNC_SDA];
         cmd_prev <= pin_q[SYNC_CMD];
         if (start_det)
         begin
            frame_open <= 1'b1;
            frame_gen <= ~frame_gen;
         end
         else if (stop_det)
            frame_open <= 1'b0;
      end
   end

   // ****************************************
   // Own address from the straps
   // ****************************************
   wire [1:0] slave_select_pin_high_q = pin_q[SYNC_HIGH0 +: 2];
   wire [1:0] slave_select_pin_low_q = pin_q[SYNC_LOW0 +: 2];
   wire high_float = slave_select_pin_high_q == PIN_FLOAT;
   wire low_float = slave_select_pin_low_q == PIN_FLOAT;
   wire high_set = slave_select_pin_high_q == PIN_HIGH;
   wire low_set = slave_select_pin_low_q == PIN_HIGH;
   wire [2:0] next_own_low =
      (!high_float && !low_float) ? {1'b0, high_set, low_set} :
      (high_float && !low_float) ? {2'b10, low_set} :
      (!high_float && low_float) ? {2'b11, high_set} : 3'b000;
   wire [6:0] own_addr = {ADDR_FIXED, next_own_low};
   wire own_valid = !(high_float && low_float);

   // ****************************************
   // Reference control state machine
   // ****************************************
   logic [23:0] cmd_word;
   ref_mode_t ref_mode;
   logic static_en, ref_power;
   logic [7:0] status_q;
   wire [3:0] cmd_code = cmd_word[COMMAND_FIELD_TOP_BIT -: 4];
   wire [1:0] cmd_opt = {cmd_word[REF_OPTION_HIGH_BIT], cmd_word[REF_OPTION_LOW_BIT]};
   wire any_channel = |channel_active_i;
   wire next_ref_power =
      (ref_mode == REF_STATIC) ? (static_en && any_channel) :
      (ref_mode == REF_FLEX_TRACK) ? any_channel :
      (ref_mode == REF_FLEX_ON);

   always_ff @(posedge clk_i)
   begin
      // Reset, or a flexible command with the mode bit clear, returns the control state to static off
      if (srst_i)
      begin
         ref_mode <= REF_MODE_RESET;
         static_en <= STATIC_EN_RESET;
         ref_power <= REF_POWER_RESET;
         status_q <= STATUS_RESET;
      end
      else
      begin
         ref_power <= next_ref_power;
         status_q <= {ref_mode, static_en, 2'b00, ref_power};
         if (cmd_evt && cmd_code == CMD_REF_STATIC && ref_mode == REF_STATIC)
            static_en <= cmd_word[REF_POWER_BIT];
         else if (cmd_evt && cmd_code == CMD_REF_FLEX)
         begin
            if (!cmd_word[FLEXIBLE_MODE_BIT])
            begin
               ref_mode <= REF_STATIC;
               static_en <= 1'b0;
            end
            else if (cmd_opt == OPT_TRACK)
               ref_mode <= REF_FLEX_TRACK;
            else if (cmd_opt == OPT_ALWAYS_ON)
               ref_mode <= REF_FLEX_ON;
            else if (cmd_opt == OPT_ALWAYS_OFF && !cmd_word[REF_POWER_BIT])
               ref_mode <= REF_FLEX_OFF;
         end
      end
   end

   assign ref_power_o = ref_power;
   assign gain_one_o = !ref_power;
   assign ref_pin_drive_o = ref_power;
   assign flexible_mode_o = ref_mode != REF_STATIC;

   // ****************************************
   // Link domain, clocked by the master's clock
   // ****************************************
   // Frame state, own address and status change only while the clock
   // is high or between commands, so they stand still at link edges.
   logic frame_seen = 1'b0;
   logic [3:0] bit_cnt;
   logic [7:0] shift, tx, ca_byte, msb_byte;
   logic master_nack, sda_low;
   phase_t phase, next_phase;
   wire in_frame = frame_open && (frame_seen == frame_gen);
   wire addr_hit = own_valid && shift[7:1] == own_addr;
   wire rw_read = shift[0];

   always_comb
   begin
      case (phase)
         PH_ADDR: next_phase = addr_hit ? (rw_read ? PH_READ : PH_CMD) : PH_IGNORE;
         PH_CMD: next_phase = PH_MSB;
         PH_MSB: next_phase = PH_LSB;
         PH_LSB: next_phase = PH_MSB;
         PH_READ: next_phase = PH_READ;
         default: next_phase = PH_IGNORE;
      endcase
   end

   // Data is taken on the rising edge, while the master holds it stable
   always_ff @(posedge scl_i)
   begin
      if (frame_seen != frame_gen)
      begin
         frame_seen <= frame_gen;
         bit_cnt <= BIT_FIRST;
         shift <= {7'h00, sda_i};
         master_nack <= 1'b0;
      end
      else if (bit_cnt == BIT_ACK)
      begin
         bit_cnt <= BIT_NONE;
         if (phase == PH_READ)
            master_nack <= sda_i;
      end
      else
      begin
         bit_cnt <= bit_cnt + 4'h1;
         shift <= {shift[6:0], sda_i};
      end
   end

   // Data line is changed only on the falling edge
   always_ff @(negedge scl_i)
   begin
      if (!in_frame)
      begin
         sda_low <= 1'b0;
         phase <= PH_ADDR;
      end
      else if (bit_cnt == BIT_ACK)
         sda_low <= (phase == PH_ADDR) ? addr_hit :
            (phase != PH_READ && phase != PH_IGNORE);
      else if (bit_cnt == BIT_NONE)
      begin
         phase <= next_phase;
         if (phase == PH_CMD)
            ca_byte <= shift;
         if (phase == PH_MSB)
            msb_byte <= shift;
         if (phase == PH_LSB)
         begin
            cmd_word <= {ca_byte, msb_byte, shift};
            cmd_tog <= ~cmd_tog;
         end
         if (next_phase == PH_READ && !master_nack)
         begin
            tx <= {status_q[6:0], 1'b0};
            sda_low <= !status_q[7];
         end
         else
            sda_low <= 1'b0;
      end
      else if (phase == PH_READ && !master_nack)
      begin
         sda_low <= !tx[7];
         tx <= {tx[6:0], 1'b0};
      end
   end

   // Open drain: only ever pull low, and never outside an open frame
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_low && frame_open;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   property p_reset_off;
      $fell(srst_i) |-> !ref_power_o && ref_mode == REF_STATIC && !static_en;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("reference not off after reset");
   property p_gain;
      ref_power_o |-> !gain_one_o;
   endproperty
   a_gain: assert property (p_gain) else $error("gain not released with internal ref");
   property p_pin;
      !ref_power_o |-> !ref_pin_drive_o;
   endproperty
   a_pin: assert property (p_pin) else $error("reference pin driven while off");
   property p_static_ignored;
      cmd_evt && cmd_code == CMD_REF_STATIC && ref_mode != REF_STATIC
         |=> $stable(ref_mode) && $stable(static_en);
   endproperty
   a_static_ignored: assert property (p_static_ignored) else $error("static command acted");
   property p_always_on;
      ref_mode == REF_FLEX_ON ##1 ref_mode == REF_FLEX_ON |=> ref_power_o;
   endproperty
   a_always_on: assert property (p_always_on) else $error("always-on reference is off");
   property p_always_off;
      ref_mode == REF_FLEX_OFF |=> !ref_power_o;
   endproperty
   a_always_off: assert property (p_always_off) else $error("always-off reference is on");
   property p_track;
      ref_mode == REF_FLEX_TRACK |=> ref_power_o == $past(any_channel);
   endproperty
   a_track: assert property (p_track) else $error("tracking reference wrong");
   property p_stop_release;
      stop_det |=> !sda_oe_o [*2];
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("bus held after stop");
   property p_flex_track;
      cmd_evt && cmd_code == CMD_REF_FLEX && cmd_word[FLEXIBLE_MODE_BIT] && cmd_opt == OPT_TRACK
         |=> ref_mode == REF_FLEX_TRACK;
   endproperty
   a_flex_track: assert property (p_flex_track) else $error("tracking not selected");
   property p_static_write;
      cmd_evt && cmd_code == CMD_REF_STATIC && ref_mode == REF_STATIC
         |=> static_en == $past(cmd_word[REF_POWER_BIT]);
   endproperty
   a_static_write: assert property (p_static_write) else $error("static power bit not taken");
   property p_start;
      start_det |=> frame_open && frame_gen != $past(frame_gen);
   endproperty
   a_start: assert property (p_start) else $error("start not detected");

endmodule
`default_nettype wire

// File: bench/i2c_master_model.sv
// Two-wire bus master model that drives the link clock and pulls the data line
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model
(
   // Link lines, the data line is resolved by the bench
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   // ********
   // Bit timing, quarter of the 80 ns link period
   // ********
   localparam int QTR = 20;

   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // Also a repeated start; clock stands high between frames
   task automatic start();
      #1;
      sda_low_o = 1'b0;
      #QTR;
      scl_o = 1'b1;
      #QTR;
      sda_low_o = 1'b1;
      // Held two quarters so the system-clock side has seen the start first
      #QTR;
      #QTR;
      scl_o = 1'b0;
      #QTR;
   endtask

   task automatic stop();
      sda_low_o = 1'b1;
      #QTR;
      scl_o = 1'b1;
      #QTR;
      sda_low_o = 1'b0;
      #QTR;
   endtask

   // Data set while the clock is low, held over the whole high phase
   task automatic clk_bit(input logic tx, output logic rx);
      sda_low_o = ~tx;
      #QTR;
      scl_o = 1'b1;
      #QTR;
      rx = sda_i;
      #QTR;
      scl_o = 1'b0;
      #QTR;
   endtask

   // Eight bits first-bit-high, ninth clock with the line released
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic rx;
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i], rx);
      clk_bit(1'b1, rx);
      ack = ~rx;
   endtask

   // One byte from the slave, answered by not-acknowledge
   task automatic get_byte(output logic [7:0] b);
      logic rx;
      for (int i = 7; i >= 0; i--)
      begin
         clk_bit(1'b1, rx);
         b[i] = rx;
      end
      clk_bit(1'b1, rx);
   endtask
endmodule
`default_nettype wire

// File: bench/ref_control_i2c_slave_tb.sv
// Self-checking bench for the reference-control two-wire slave
`timescale 1ns/1ns
`default_nettype none
module ref_control_i2c_slave_tb
   import ref_i2c_pkg::*;
;
   logic clk_i, srst_i, scl, m_low, sda_o_w, sda_oe_w, pwr, gain, drive, flex;
   wire sda_bus;
   logic [1:0] sel_hi, sel_lo;
   logic [7:0] chan;
   int mismatches = 0;
   int checks = 0;
   int seed = 95;
   int e_mode;
   logic e_sen;
   logic [3:0] notes [$];
   event note_ready;

   // Open-drain wire with pull-up
   assign sda_bus = ~(m_low | (sda_oe_w & ~sda_o_w));

   i2c_master_model m_u (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_bus));

   ref_control_i2c_slave dut_u (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_bus),
      .sda_o(sda_o_w), .sda_oe_o(sda_oe_w), .slave_select_pin_high_i(sel_hi),
      .slave_select_pin_low_i(sel_lo), .channel_active_i(chan), .ref_power_o(pwr),
      .gain_one_o(gain), .ref_pin_drive_o(drive), .flexible_mode_o(flex));

   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // ********
   // Checking
   // ********
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(note_ready)
      check({4'h0, flex, pwr, gain, drive}, {4'h0, notes.pop_front()});

   function automatic logic exp_pwr();
      case (e_mode)
         0: return e_sen & (|chan);
         1: return |chan;
         2: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Settling covers mode update plus output register
   task automatic note();
      logic p;
      repeat (20) @(negedge clk_i);
      p = exp_pwr();
      notes.push_back({e_mode != 0, p, ~p, p});
      -> note_ready;
   endtask

   // ********
   // Bus transfers
   // ********
   function automatic logic [7:0] addr_w();
      logic [2:0] a;
      if (sel_hi == PIN_FLOAT)
         a = {2'b10, sel_lo[0]};
      else if (sel_lo == PIN_FLOAT)
         a = {2'b11, sel_hi[0]};
      else
         a = {1'b0, sel_hi[0], sel_lo[0]};
      return {ADDR_FIXED, a, 1'b0};
   endfunction

   task automatic frame(input logic [47:0] w, input int n, input logic want, input logic fin);
      logic ack;
      m_u.start();
      for (int i = 0; i < n; i++)
      begin
         m_u.put_byte(w[47-8*i -: 8], ack);
         check({7'h0, ack}, {7'h0, want});
         if (ack !== 1'b1)
            break;
      end
      if (fin)
         m_u.stop();
   endtask

   task automatic ref_cmd(input logic [3:0] c, input logic [7:0] msb, input logic [7:0] lsb);
      frame({addr_w(), c, 4'h5, msb, lsb, 16'h0}, 4, 1'b1, 1'b1);
   endtask

   // ********
   // Scenarios
   // ********
   initial
   begin
      logic [7:0] r;
      logic [7:0] bad [4];
      logic ack;
      srst_i = 1'b1;
      chan = 8'h00;
      sel_hi = PIN_LOW;
      sel_lo = PIN_FLOAT;
      e_mode = 0;
      e_sen = 1'b0;
      repeat (10) @(negedge clk_i);
      srst_i = 1'b0;
      note();
      // Another strap, general call, ten-bit prefix, high-speed code
      bad = '{addr_w() ^ 8'h04, 8'h00, 8'hf0, 8'h08};
      foreach (bad[k])
         frame({bad[k], 40'h0}, 1, 1'b0, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         @(negedge clk_i);
         do
         begin
            sel_hi = 2'({$random(seed)} % 3);
            sel_lo = 2'({$random(seed)} % 3);
         end
         while (sel_hi == PIN_FLOAT && sel_lo == PIN_FLOAT);
         chan = 8'($random(seed));
         r = 8'($random(seed));
         e_sen = (k == 3) | r[4];
         r[4] = e_sen;
         ref_cmd(CMD_REF_STATIC, 8'($random(seed)), r);
         note();
         chan = k[0] ? 8'h00 : ~chan;
         note();
      end
      chan = 8'h10;
      // Static off cut short, then a repeated start carries flexible tracking
      frame({addr_w(), CMD_REF_STATIC, 4'h0, 8'h00, 8'h00, 16'h0}, 3, 1'b1, 1'b0);
      ref_cmd(CMD_REF_FLEX, 8'h40, 8'h00);
      e_mode = 1;
      note();
      chan = 8'h00;
      note();
      // Second word reuses the command byte
      frame({addr_w(), CMD_REF_FLEX, 4'h0, 8'h40, 8'h00, 8'h50, 8'h00}, 6, 1'b1, 1'b1);
      e_mode = 2;
      note();
      chan = 8'h81;
      note();
      ref_cmd(CMD_REF_STATIC, 8'h00, 8'h00);
      note();
      ref_cmd(CMD_REF_FLEX, 8'h60, 8'h00);
      e_mode = 3;
      note();
      ref_cmd(CMD_REF_FLEX, 8'h60, 8'h10);
      note();
      m_u.start();
      m_u.put_byte(addr_w() | 8'h01, ack);
      check({7'h0, ack}, 8'h01);
      m_u.get_byte(r);
      m_u.stop();
      check(r, {4'(4'h1 << e_mode), e_sen, 2'b00, exp_pwr()});
      ref_cmd(CMD_REF_FLEX, 8'h00, 8'h10);
      e_mode = 0;
      e_sen = 1'b0;
      note();
      ref_cmd(CMD_REF_STATIC, 8'h00, 8'h10);
      e_sen = 1'b1;
      note();
      ref_cmd(CMD_REF_FLEX, 8'h50, 8'h00);
      e_mode = 2;
      note();
      srst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      srst_i = 1'b0;
      e_mode = 0;
      e_sen = 1'b0;
      note();
      test_done();
   end

   // Watchdog well beyond the roughly 47 us of traffic
   initial
   begin
      #200000;
      mismatches++;
      test_done();
   end
endmodule
`default_nettype wire
